// ---- include/i2csp_pkg.sv ----
// package: constants and carrier types of the two-wire slave port
package i2csp_pkg;
   // mode field codes (four-bit mode select)
   localparam logic [3:0] MODE_SLV7    = 4'h6;
   localparam logic [3:0] MODE_SLV10   = 4'h7;
   localparam logic [3:0] MODE_HWMST   = 4'h8;
   localparam logic [3:0] MODE_FWMST   = 4'hb;
   localparam logic [3:0] MODE_SLV7SP  = 4'he;
   localparam logic [3:0] MODE_SLV10SP = 4'hf;

   // bit counter marks within one byte frame
   localparam logic [3:0] CNT_ZERO  = 4'h0;
   localparam logic [3:0] CNT_BYTE  = 4'h8;
   localparam logic [3:0] CNT_ACK   = 4'h9;
   // header of the first byte of a ten-bit address
   localparam logic [4:0] TEN_HDR   = 5'h1e;
   // master clock: half period is 2*(n+1) cycles, so scl = fosc/(4*(n+1))
   localparam int         MST_HALF_MUL = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RX   = 3'b010,
      ST_TX   = 3'b100
   } i2csp_state_t;

   // software strobes, each a one-cycle pulse, with the eight-bit buffer write data
   typedef struct packed {
      logic       buf_rd;
      logic       buf_wr;
      logic [7:0] wdata;
      logic       addr_wr;
      logic       ovf_clr;
      logic       evt_clr;
      logic       ckp_set;
   } i2csp_cmd_t;

   typedef struct packed {
      logic [7:0] buf_data;
      logic [7:0] own_addr;
      logic       buffer_full;
      logic       overflow;
      logic       event_flag;
      logic       addr_update;
      logic       rw_dir;
      logic       start_seen;
      logic       stop_seen;
      logic       clock_release;
   } i2csp_status_t;

   // open-drain pins: outputs always low, enables pull the line
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } i2csp_pins_t;
endpackage

// ---- src/i2csp_line_watch.sv ----
// line watcher: scl edge pulses and start/stop condition pulses from scl and sda
`timescale 1ns/1ps
module i2csp_line_watch (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det
);
   logic scl_ff;
   logic sda_ff;

   // previous line levels; reset to idle-high so release makes no edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_ff <= scl_i;
         sda_ff <= sda_i;
      end
   end

   // sda moving while scl stays high marks start or stop
   assign scl_rise  = scl_i & ~scl_ff;
   assign scl_fall  = ~scl_i & scl_ff;
   assign start_det = scl_i & scl_ff & sda_ff & ~sda_i;
   assign stop_det  = scl_i & scl_ff & ~sda_ff & sda_i;
endmodule // i2csp_line_watch

// ---- src/i2csp_slave_port.sv ----
// two-wire serial port: slave engine, legacy event modes, clock divider
`timescale 1ns/1ps
module i2csp_slave_port (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    module_enable_bit,
   input  wire logic [3:0]              mode_sel,
   input  wire logic                    fw_scl_dir,
   input  wire logic                    fw_sda_dir,
   input  wire i2csp_pkg::i2csp_cmd_t   cmd,
   input  wire logic [7:0]              addr_wdata,
   input  wire logic                    scl_i,
   input  wire logic                    sda_i,
   output i2csp_pkg::i2csp_pins_t       pins_ff,
   output i2csp_pkg::i2csp_status_t     status_ff
);
   i2csp_pkg::i2csp_state_t state_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] buf_ff;
   logic [7:0] own_ff;
   logic       addr_ff;      // next byte is an address byte
   logic       addr_lo_ff;   // next address byte is the ten-bit low half
   logic       ten_ok_ff;    // full ten-bit address matched since last stop
   logic       ack_ff;       // drive acknowledge during ninth bit
   logic       acc_ff;       // byte of this frame was accepted
   logic       tx_go_ff;     // enter transmit after ninth fall
   logic       mack_ff;      // master answer latched on ninth rise
   logic       bf_ff;
   logic       ovf_ff;
   logic       evt_ff;
   logic       ua_ff;
   logic       rw_ff;
   logic       s_ff;
   logic       p_ff;
   logic       ckp_ff;
   logic [8:0] div_ff;
   logic       mclk_ff;
   i2csp_pkg::i2csp_pins_t nxt_pins;

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   i2csp_line_watch u_watch (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   // mode decode
   logic ten_mode;
   logic sp_mode;
   logic slave_on;
   logic fw_mode;
   logic hw_mode;
   assign ten_mode = (mode_sel == i2csp_pkg::MODE_SLV10) ||
                     (mode_sel == i2csp_pkg::MODE_SLV10SP);
   assign sp_mode  = (mode_sel == i2csp_pkg::MODE_SLV7SP) ||
                     (mode_sel == i2csp_pkg::MODE_SLV10SP);
   assign fw_mode  = module_enable_bit && (mode_sel == i2csp_pkg::MODE_FWMST);
   assign hw_mode  = module_enable_bit && (mode_sel == i2csp_pkg::MODE_HWMST);
   assign slave_on = module_enable_bit && (ten_mode || sp_mode ||
                     (mode_sel == i2csp_pkg::MODE_SLV7));

   // frame points: eighth falling edge and ninth falling edge
   logic byte_end;
   logic ack_end;
   logic tx_end;
   logic rx_end;
   assign byte_end = slave_on && scl_fall && (cnt_ff == i2csp_pkg::CNT_BYTE);
   assign ack_end  = slave_on && scl_fall && (cnt_ff == i2csp_pkg::CNT_ACK);
   assign rx_end   = byte_end && (state_ff == i2csp_pkg::ST_RX);
   assign tx_end   = ack_end && (state_ff == i2csp_pkg::ST_TX);

   // address compare and buffer decision for a completed received byte
   logic hi_match;
   logic match;
   logic want_rd;
   logic accept;
   logic do_load;
   always_comb begin
      hi_match = (shift_ff[7:1] == own_ff[7:1]) &&
                 (!ten_mode || shift_ff[7:3] == i2csp_pkg::TEN_HDR);
      want_rd  = shift_ff[0];
      if (!addr_ff)
         match = 1'b1;
      else if (ten_mode && addr_lo_ff)
         match = (shift_ff == own_ff);
      else if (ten_mode && want_rd)
         match = hi_match && ten_ok_ff;
      else
         match = hi_match;
      accept  = rx_end && match;
      do_load = accept && !bf_ff;
   end

   // receive, transmit and framing sequencer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_ff   <= i2csp_pkg::ST_IDLE;
         cnt_ff     <= i2csp_pkg::CNT_ZERO;
         shift_ff   <= 8'h00;
         addr_ff    <= 1'b0;
         addr_lo_ff <= 1'b0;
         ten_ok_ff  <= 1'b0;
         ack_ff     <= 1'b0;
         acc_ff     <= 1'b0;
         tx_go_ff   <= 1'b0;
         mack_ff    <= 1'b0;
      end else if (!slave_on) begin
         // leaving the slave modes abandons any transfer
         state_ff  <= i2csp_pkg::ST_IDLE;
         cnt_ff    <= i2csp_pkg::CNT_ZERO;
         ack_ff    <= 1'b0;
         ten_ok_ff <= 1'b0;
         if (cmd.buf_wr) shift_ff <= cmd.wdata;
      end else if (stop_det) begin
         state_ff  <= i2csp_pkg::ST_IDLE;
         ack_ff    <= 1'b0;
         ten_ok_ff <= 1'b0;
      end else if (start_det) begin
         // a repeated start keeps ten_ok so a read needs only the high byte
         state_ff   <= i2csp_pkg::ST_RX;
         cnt_ff     <= i2csp_pkg::CNT_ZERO;
         addr_ff    <= 1'b1;
         addr_lo_ff <= 1'b0;
         ack_ff     <= 1'b0;
      end else begin
         if (cmd.buf_wr) shift_ff <= cmd.wdata;
         if (scl_rise && state_ff != i2csp_pkg::ST_IDLE) begin
            if (cnt_ff < i2csp_pkg::CNT_BYTE) begin
               cnt_ff <= cnt_ff + 4'h1;
               if (state_ff == i2csp_pkg::ST_RX)
                  shift_ff <= {shift_ff[6:0], sda_i};
            end else if (cnt_ff == i2csp_pkg::CNT_BYTE) begin
               cnt_ff  <= i2csp_pkg::CNT_ACK;
               mack_ff <= sda_i;
            end
         end
         // transmit data changes only on falling scl; ones fill in so the
         // eighth fall leaves sda released for the master's answer
         if (scl_fall && state_ff == i2csp_pkg::ST_TX && cnt_ff != i2csp_pkg::CNT_ZERO &&
             cnt_ff <= i2csp_pkg::CNT_BYTE)
            shift_ff <= {shift_ff[6:0], 1'b1};
         if (rx_end) begin
            if (!match) begin
               state_ff <= i2csp_pkg::ST_IDLE;
            end else begin
               ack_ff   <= !bf_ff && !ovf_ff;
               acc_ff   <= 1'b1;
               tx_go_ff <= addr_ff && !addr_lo_ff && want_rd;
            end
         end
         if (ack_end && state_ff == i2csp_pkg::ST_RX) begin
            ack_ff <= 1'b0;
            acc_ff <= 1'b0;
            cnt_ff <= i2csp_pkg::CNT_ZERO;
            // a withheld acknowledge ends our part in the frame
            if (!ack_ff) begin
               state_ff <= i2csp_pkg::ST_IDLE;
            end else if (tx_go_ff) begin
               state_ff <= i2csp_pkg::ST_TX;
               tx_go_ff <= 1'b0;
            end else if (addr_ff && ten_mode && !addr_lo_ff) begin
               addr_lo_ff <= 1'b1;
            end else if (addr_ff) begin
               addr_ff    <= 1'b0;
               addr_lo_ff <= 1'b0;
               ten_ok_ff  <= ten_mode;
            end
         end
         if (tx_end) begin
            cnt_ff <= i2csp_pkg::CNT_ZERO;
            if (mack_ff) state_ff <= i2csp_pkg::ST_IDLE;
         end
      end
   end

   // event flag: set wins over a software clear in the same cycle
   logic evt_set;
   assign evt_set = (ack_end && state_ff == i2csp_pkg::ST_RX && acc_ff) || tx_end ||
                    ((sp_mode && slave_on) || fw_mode) && (start_det || stop_det);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         evt_ff <= 1'b0;
      else
         evt_ff <= evt_set || (evt_ff && !cmd.evt_clr);
   end

   // buffer, full and overflow flags
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buf_ff <= 8'h00;
         bf_ff  <= 1'b0;
         ovf_ff <= 1'b0;
      end else begin
         if (do_load)
            buf_ff <= shift_ff;
         else if (cmd.buf_wr)
            buf_ff <= cmd.wdata;
         bf_ff  <= do_load || cmd.buf_wr ||
                   (bf_ff && !cmd.buf_rd && !(byte_end && state_ff == i2csp_pkg::ST_TX));
         ovf_ff <= (accept && bf_ff) || (ovf_ff && !cmd.ovf_clr);
      end
   end

   // address register, update flag, direction and clock release
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         own_ff <= 8'h00;
         ua_ff  <= 1'b0;
         rw_ff  <= 1'b0;
         ckp_ff <= 1'b1;
      end else begin
         if (cmd.addr_wr) own_ff <= addr_wdata;
         // acknowledged ten-bit write address bytes hold scl until the address is rewritten
         ua_ff <= (ack_end && state_ff == i2csp_pkg::ST_RX && ack_ff && addr_ff &&
                   ten_mode && !tx_go_ff) || (ua_ff && !cmd.addr_wr && slave_on);
         if (rx_end && match && addr_ff && !addr_lo_ff)
            rw_ff <= want_rd;
         else if (tx_end && mack_ff)
            rw_ff <= 1'b0;
         if ((ack_end && state_ff == i2csp_pkg::ST_RX && ack_ff && tx_go_ff) ||
             (tx_end && !mack_ff))
            ckp_ff <= 1'b0;
         else if (cmd.ckp_set)
            ckp_ff <= 1'b1;
      end
   end

   // start and stop status, cleared while disabled
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_ff <= 1'b0;
         p_ff <= 1'b0;
      end else if (!module_enable_bit) begin
         s_ff <= 1'b0;
         p_ff <= 1'b0;
      end else if (start_det) begin
         s_ff <= 1'b1;
         p_ff <= 1'b0;
      end else if (stop_det) begin
         s_ff <= 1'b0;
         p_ff <= 1'b1;
      end
   end

   // master scl divider; the reload comes from the address register
   logic [8:0] half_cnt;
   assign half_cnt = 9'(i2csp_pkg::MST_HALF_MUL * (int'(own_ff) + 1) - 1);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_ff  <= 9'h000;
         mclk_ff <= 1'b1;
      end else if (!hw_mode) begin
         div_ff  <= 9'h000;
         mclk_ff <= 1'b1;
      end else if (div_ff >= half_cnt) begin
         div_ff  <= 9'h000;
         mclk_ff <= !mclk_ff;
      end else begin
         div_ff <= div_ff + 9'h001;
      end
   end

   // pin drive; enables are registered so the pins never glitch
   always_comb begin
      nxt_pins = '0;
      if (fw_mode) begin
         nxt_pins.scl_oe = !fw_scl_dir;
         nxt_pins.sda_oe = !fw_sda_dir;
      end else if (hw_mode) begin
         nxt_pins.scl_oe = !mclk_ff;
      end else if (slave_on) begin
         nxt_pins.scl_oe = ua_ff || (state_ff == i2csp_pkg::ST_TX && !ckp_ff);
         nxt_pins.sda_oe = ack_ff || (state_ff == i2csp_pkg::ST_TX && ckp_ff &&
                           cnt_ff <= i2csp_pkg::CNT_BYTE && !shift_ff[7]);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         pins_ff <= '0;
      else
         pins_ff <= nxt_pins;
   end

   assign status_ff = '{buf_data: buf_ff, own_addr: own_ff, buffer_full: bf_ff,
                        overflow: ovf_ff, event_flag: evt_ff, addr_update: ua_ff,
                        rw_dir: rw_ff, start_seen: s_ff, stop_seen: p_ff,
                        clock_release: ckp_ff};

   // checks on the slave engine and the pin drive
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_off_no_drive: assert property (!module_enable_bit |=> !pins_ff.scl_oe && !pins_ff.sda_oe)
      else $error("pins driven while disabled");
   a_rx_load_buf: assert property (do_load |=> bf_ff && buf_ff == $past(shift_ff))
      else $error("received byte not moved to buffer");
   a_full_keeps: assert property (accept && bf_ff |=> ovf_ff && buf_ff == $past(buf_ff))
      else $error("full buffer overwritten or overflow missed");
   a_nack_busy: assert property (accept && (bf_ff || ovf_ff) |=> !ack_ff [*2])
      else $error("acknowledge given while busy");
   a_ack_free: assert property (accept && !bf_ff && !ovf_ff |=> ack_ff ##1 pins_ff.sda_oe)
      else $error("acknowledge not driven");
   a_evt_ninth: assert property (evt_set |=> evt_ff)
      else $error("event flag not set");
   a_sp_event: assert property (sp_mode && slave_on && start_det |=> evt_ff)
      else $error("start event missed");
   a_fw_pins: assert property (fw_mode |=> pins_ff.scl_oe == !$past(fw_scl_dir) &&
                               pins_ff.sda_oe == !$past(fw_sda_dir))
      else $error("firmware pin drive wrong");
   a_ua_stretch: assert property (slave_on && ua_ff && !fw_mode |=> pins_ff.scl_oe)
      else $error("address update not stretching");
   a_tx_stretch: assert property (slave_on && state_ff == i2csp_pkg::ST_TX && !ckp_ff
                                  |=> pins_ff.scl_oe)
      else $error("transmit not stretching");
   a_master_nack: assert property (tx_end && mack_ff && !start_det && !stop_det
                                   |=> state_ff == i2csp_pkg::ST_IDLE && !rw_ff)
      else $error("nack did not end transmit");
   a_ovf_sticky: assert property (ovf_ff && !cmd.ovf_clr |=> ovf_ff)
      else $error("overflow lost without clear");

   c_rx_accept: cover property (accept && !bf_ff && !ovf_ff);
   c_tx_nack: cover property (tx_end && mack_ff);
   c_ten_update: cover property (ua_ff ##1 cmd.addr_wr);
endmodule // i2csp_slave_port

// ---- bench/i2csp_bus_master.sv ----
// bus master model: drives the two-wire bus through open-drain pulls
`timescale 1ns/1ps
module i2csp_bus_master #(
   parameter int HALF = 20
) (
   input  wire logic sys_clk,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic slow,
   output logic      scl_low,
   output logic      sda_low,
   output logic      hung
);
   // both lines released at start, pull-ups hold them high
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      hung    = 1'b0;
   end

   // one half bit time; a slow master stays three times as long
   task automatic half();
      repeat (slow ? 3 * HALF : HALF) @(negedge sys_clk);
   endtask

   // release scl and wait for it; the slave may stretch, so the wait is bounded
   task automatic scl_up();
      int n;
      n = 0;
      scl_low = 1'b0;
      while (!scl && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 3000) hung = 1'b1;
   endtask

   // sda falls while scl is high
   task automatic start_cond();
      sda_low = 1'b1;
      half();
      scl_low = 1'b1;
      half();
   endtask

   task automatic rstart_cond();
      sda_low = 1'b0;
      half();
      scl_up();
      half();
      start_cond();
   endtask

   // sda rises while scl is high
   task automatic stop_cond();
      sda_low = 1'b1;
      half();
      scl_up();
      half();
      sda_low = 1'b0;
      half();
   endtask

   // data changes only while scl is low, sampled while scl is high
   task automatic bit_cycle(input logic b, output logic r);
      sda_low = !b;
      half();
      scl_up();
      half();
      r = sda;
      scl_low = 1'b1;
   endtask

   // msb first, then the ninth pulse reads the slave's answer
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
      bit_cycle(1'b1, r);
      ack = !r;
   endtask

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
      bit_cycle(!ack, r);
   endtask
endmodule // i2csp_bus_master

// ---- bench/tb_i2c_slave_port.sv ----
// testbench: two-wire slave port against the bus master model
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_i2c_slave_port;
   logic                     sys_clk, rst, module_enable_bit, fw_scl_dir, fw_sda_dir;
   logic [3:0]               mode_sel;
   logic [7:0]               addr_wdata, d;
   i2csp_pkg::i2csp_cmd_t    cmd;
   i2csp_pkg::i2csp_pins_t   pins;
   i2csp_pkg::i2csp_status_t st;
   logic                     scl, sda, m_scl_low, m_sda_low, hung, slow, ack;
   int                       err_count, n_compared, cyc, n;
   logic [3:0]               ev_modes [2] = '{i2csp_pkg::MODE_SLV7SP, i2csp_pkg::MODE_SLV10SP};

   // wired-and lines with pull-ups: any party pulling wins
   assign scl = !(m_scl_low | pins.scl_oe);
   assign sda = !(m_sda_low | pins.sda_oe);

   i2csp_slave_port dut (
      .sys_clk           (sys_clk),
      .rst               (rst),
      .module_enable_bit (module_enable_bit),
      .mode_sel          (mode_sel),
      .fw_scl_dir        (fw_scl_dir),
      .fw_sda_dir        (fw_sda_dir),
      .cmd               (cmd),
      .addr_wdata        (addr_wdata),
      .scl_i             (scl),
      .sda_i             (sda),
      .pins_ff           (pins),
      .status_ff         (st)
   );

   i2csp_bus_master #(.HALF(20)) bm (
      .sys_clk (sys_clk),
      .scl     (scl),
      .sda     (sda),
      .slow    (slow),
      .scl_low (m_scl_low),
      .sda_low (m_sda_low),
      .hung    (hung)
   );

   always #5 sys_clk = ~sys_clk;

   // cycle ceiling, several times the expected run length
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // flags settle a few cycles after the synchronised scl edge
   task automatic settle();
      repeat (6) @(negedge sys_clk);
   endtask

   // one-cycle software strobes: buffer read, event clear, overflow clear
   task automatic sw(input logic rd, input logic ce, input logic co);
      @(negedge sys_clk);
      cmd.buf_rd  = rd;
      cmd.evt_clr = ce;
      cmd.ovf_clr = co;
      @(negedge sys_clk);
      cmd = '0;
   endtask

   task automatic set_addr(input logic [7:0] a);
      @(negedge sys_clk);
      addr_wdata   = a;
      cmd.addr_wr  = 1'b1;
      @(negedge sys_clk);
      cmd = '0;
   endtask

   // buffer first, clock release after, never the other way round
   task automatic tx_load(input logic [7:0] b);
      @(negedge sys_clk);
      cmd.buf_wr = 1'b1;
      cmd.wdata  = b;
      @(negedge sys_clk);
      cmd         = '0;
      cmd.ckp_set = 1'b1;
      @(negedge sys_clk);
      cmd = '0;
   endtask

   task automatic wr(input logic [7:0] b, input logic exp_ack);
      bm.write_byte(b, ack);
      settle();
      `CHK(ack, exp_ack)
   endtask

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      module_enable_bit = 1'b0;
      mode_sel = 4'h0;
      fw_scl_dir = 1'b1;
      fw_sda_dir = 1'b1;
      cmd = '0;
      addr_wdata = 8'h00;
      slow = 1'b0;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      `CHK(st, 24'h000001)
      `CHK(pins, 4'h0)
      // a disabled port ignores a matching address
      mode_sel = i2csp_pkg::MODE_SLV7;
      module_enable_bit = 1'b1;
      set_addr(8'h5b);
      module_enable_bit = 1'b0;
      bm.start_cond();
      wr(8'h5a, 1'b0);
      `CHK(st.event_flag, 1'b0)
      bm.stop_cond();
      module_enable_bit = 1'b1;
      set_addr(8'h5b);
      // plain slave: start raises no event; bit 0 left out of the compare
      bm.start_cond();
      settle();
      `CHK(st.event_flag, 1'b0)
      wr(8'h5a, 1'b1);
      `CHK({st.buf_data, st.buffer_full, st.rw_dir, st.event_flag}, 11'h2d5)
      sw(1'b1, 1'b1, 1'b0);
      wr(8'h3c, 1'b1);
      `CHK({st.buf_data, st.event_flag}, 9'h079)
      sw(1'b0, 1'b1, 1'b0);
      // unread buffer: refused, kept, overflow raised
      wr(8'hc3, 1'b0);
      `CHK({st.buf_data, st.overflow, st.event_flag}, 10'h0f3)
      bm.stop_cond();
      sw(1'b1, 1'b1, 1'b0);
      `CHK({st.buffer_full, st.overflow}, 2'b01)
      // overflow left set: byte loaded but not acknowledged
      bm.start_cond();
      wr(8'h5a, 1'b0);
      `CHK({st.buf_data, st.event_flag}, 9'h0b5)
      bm.stop_cond();
      sw(1'b1, 1'b1, 1'b1);
      `CHK(st.overflow, 1'b0)
      bm.start_cond();
      wr(8'h5c, 1'b0);
      `CHK(st.event_flag, 1'b0)
      bm.stop_cond();
      // slave transmit with a slow master
      bm.start_cond();
      wr(8'h5b, 1'b1);
      `CHK({st.rw_dir, pins.scl_oe}, 2'b11)
      sw(1'b1, 1'b1, 1'b0);
      slow = 1'b1;
      tx_load(8'ha5);
      bm.read_byte(1'b1, d);
      `CHK(d, 8'ha5)
      settle();
      `CHK({st.rw_dir, st.event_flag}, 2'b11)
      sw(1'b0, 1'b1, 1'b0);
      tx_load(8'h96);
      bm.read_byte(1'b0, d);
      `CHK(d, 8'h96)
      settle();
      `CHK(st.rw_dir, 1'b0)
      slow = 1'b0;
      bm.stop_cond();
      // ten-bit: header, low byte, repeated start for a read
      mode_sel = i2csp_pkg::MODE_SLV10;
      set_addr(8'hf6);
      sw(1'b1, 1'b1, 1'b0);
      bm.start_cond();
      wr({i2csp_pkg::TEN_HDR, 2'b11, 1'b0}, 1'b1);
      `CHK({st.addr_update, st.buffer_full, st.event_flag, pins.scl_oe}, 4'hf)
      set_addr(8'h34);
      sw(1'b1, 1'b1, 1'b0);
      `CHK(pins.scl_oe, 1'b0)
      wr(8'h34, 1'b1);
      `CHK(st.addr_update, 1'b1)
      set_addr(8'hf6);
      sw(1'b1, 1'b1, 1'b0);
      bm.rstart_cond();
      wr(8'hf7, 1'b1);
      `CHK({st.rw_dir, st.buffer_full}, 2'b11)
      sw(1'b1, 1'b1, 1'b0);
      tx_load(8'h81);
      bm.read_byte(1'b0, d);
      `CHK(d, 8'h81)
      bm.stop_cond();
      // event modes flag both start and stop
      foreach (ev_modes[i]) begin
         mode_sel = ev_modes[i];
         sw(1'b0, 1'b1, 1'b0);
         bm.start_cond();
         settle();
         `CHK(st.event_flag, 1'b1)
         sw(1'b0, 1'b1, 1'b0);
         bm.stop_cond();
         settle();
         `CHK(st.event_flag, 1'b1)
      end
      // firmware master: cleared direction pulls the pin low
      mode_sel = i2csp_pkg::MODE_FWMST;
      fw_scl_dir = 1'b0;
      fw_sda_dir = 1'b0;
      settle();
      `CHK(pins, 4'b0101)
      fw_scl_dir = 1'b1;
      fw_sda_dir = 1'b1;
      settle();
      `CHK(pins, 4'b0000)
      // master clock: half period is 4*(2+1)/2 cycles for own address 2
      set_addr(8'h02);
      mode_sel = i2csp_pkg::MODE_HWMST;
      n = 0;
      d[0] = pins.scl_oe;
      while (pins.scl_oe === d[0] && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      d[0] = pins.scl_oe;
      while (pins.scl_oe === d[0] && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(n, 4 * (2 + 1) / 2)
      mode_sel = 4'h0;
      settle();
      `CHK(hung, 1'b0)
      end_sim();
   end
endmodule // tb_i2c_slave_port
